/* File: pkg/lmt_map.svh */
// Purpose: Constants for loop mode control and cycle timing
// Assumes: Costs packed as {clocks[7:0], reads[3:0], writes[3:0]}
// Notes:   Four-clock bus cycles, no wait states included
`ifndef LMT_MAP_SVH
`define LMT_MAP_SVH
`define LMT_LOOP_DISP       16'hFFFC
`define LMT_WAIT_CLK        8'h01
`define LMT_COST_ZERO       16'h0000
`define LMT_EA_IND_F_BW     16'h0410
`define LMT_EA_IND_F_L      16'h0820
`define LMT_EA_IND_N        16'h0200
`define LMT_EA_POST_F_BW    16'h0410
`define LMT_EA_POST_F_L     16'h0820
`define LMT_EA_POST_N       16'h0400
`define LMT_EA_PRE_F_BW     16'h0810
`define LMT_EA_PRE_F_L      16'h0A20
`define LMT_EA_PRE_N        16'h0400
`define LMT_EA_DISP_F_BW    16'h0820
`define LMT_EA_DISP_F_L     16'h0C30
`define LMT_EA_DISP_N_BW    16'h0400
`define LMT_EA_DISP_N_L     16'h0410
`define LMT_EA_IDX_F_BW     16'h0A20
`define LMT_EA_IDX_F_L      16'h0E30
`define LMT_EA_IDX_N        16'h0810
`define LMT_EA_ABSW_F_BW    16'h0820
`define LMT_EA_ABSW_F_L     16'h0C30
`define LMT_EA_ABSW_N       16'h0410
`define LMT_EA_ABSL_F_BW    16'h0C30
`define LMT_EA_ABSL_F_L     16'h1040
`define LMT_EA_ABSL_N       16'h0820
`define LMT_EA_PCD_F_BW     16'h0820
`define LMT_EA_PCD_F_L      16'h0C30
`define LMT_EA_PCX_F_BW     16'h0A20
`define LMT_EA_PCX_F_L      16'h0E30
`define LMT_EA_IMM_F_BW     16'h0410
`define LMT_EA_IMM_F_L      16'h0820
`define LMT_MOVE_BASE       16'h0410
`define LMT_MOVE_WR_BW      16'h0401
`define LMT_MOVE_WR_L       16'h0802
`define LMT_MOVE_PRE_SRC_BW 16'h0610
`define LMT_MOVE_DST_DISP   16'h0410
`define LMT_MOVE_DST_IDX    16'h0610
`define LMT_MOVE_DST_ABSW   16'h0410
`define LMT_MOVE_DST_ABSL   16'h0820
`endif

/* File: pkg/lmt_pkg.sv */
// Purpose: Types for loop mode control and cycle timing
// Assumes: Constants live in lmt_map.svh
// Notes:   None
package lmt_pkg;
  typedef enum logic [3:0] {
    ea_dn, ea_an, ea_ind, ea_post, ea_pre, ea_disp, ea_idx,
    ea_absw, ea_absl, ea_pcd, ea_pcx, ea_imm
  } lmt_ea_mode_t;
  typedef struct packed {
    logic [7:0] clocks;
    logic [3:0] reads;
    logic [3:0] writes;
  } lmt_cost_t;
  typedef struct packed {
    logic        valid;
    logic        taken;
    logic [15:0] disp;
  } lmt_decrement_and_branch_t;
  typedef struct packed {
    logic         valid;
    lmt_ea_mode_t mode;
    logic         size_long;
    logic         fetch;
  } lmt_ea_req_t;
  typedef struct packed {
    logic         valid;
    lmt_ea_mode_t src;
    lmt_ea_mode_t dst;
    logic         size_long;
  } lmt_move_req_t;
  typedef enum logic {arm_idle, arm_wait} lmt_arm_state_t;
endpackage

/* File: design/lmt_ctrl.sv */
// Purpose: Loop mode sequencing and instruction cycle cost tracking
// Assumes: Core presents decode events as one-cycle pulses on core_clk
// Notes:   Cost figures assume four-clock bus cycles plus waits
`include "lmt_map.svh"
module lmt_ctrl
  import lmt_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          opword_valid,
  input  wire logic [15:0]   opword,
  input  wire lmt_decrement_and_branch_t     decrement_and_branch,
  input  wire logic          instr_boundary,
  input  wire logic          irq_pending,
  input  wire logic          trace_en,
  input  wire logic          bus_error,
  input  wire logic          rte_resume,
  input  wire lmt_ea_req_t   ea_req,
  input  wire lmt_move_req_t move_req,
  input  wire logic          wait_state,
  output logic               loop_active,
  output logic               irq_take,
  output logic               trace_take,
  output logic               loop_exit,
  output logic               skip_refetch,
  output logic               cost_valid,
  output lmt_cost_t          cost
);

  lmt_arm_state_t arm_state;
  lmt_arm_state_t next_arm_state;
  logic           resume_pending;
  logic           next_resume_pending;
  logic           next_loop_active;
  logic           next_irq_take;
  logic           next_trace_take;
  logic           next_loop_exit;
  logic           next_skip_refetch;
  logic           next_cost_valid;
  lmt_cost_t      next_cost;
  logic           enter_loop;
  logic           exit_cond;
  logic           exit_branch;
  logic           exit_irq;
  logic           exit_trace;
  logic           exit_bus;
  logic           entry_block;

  function automatic logic is_indirect(input logic [2:0] mode);
    is_indirect = (mode == 3'h2) || (mode == 3'h3) || (mode == 3'h4);
  endfunction

  // Loopable one-word instruction decode
  function automatic logic loopable(input logic [15:0] op);
    logic [2:0] dst_mode;
    logic [2:0] src_mode;
    logic [2:0] opmode;
    logic       ok;
    dst_mode = op[8:6];
    src_mode = op[5:3];
    opmode   = op[8:6];
    ok       = 1'b0;
    if ((op[15:14] == 2'h0) && (op[13:12] != 2'h0)) begin
      if (is_indirect(src_mode) && is_indirect(dst_mode)) begin
        ok = 1'b1;
      end
      if ((src_mode == 3'h0) && ((dst_mode == 3'h2) || (dst_mode == 3'h3))) begin
        ok = 1'b1;
      end
      if ((src_mode == 3'h1) && (op[13:12] != 2'h1) &&
          ((dst_mode == 3'h2) || (dst_mode == 3'h3))) begin
        ok = 1'b1;
      end
    end
    // Arithmetic and compare forms into a data register
    if ((op[15:12] == 4'hD) || (op[15:12] == 4'hC) || (op[15:12] == 4'hB) ||
        (op[15:12] == 4'h8) || (op[15:12] == 4'h9)) begin
      if ((opmode <= 3'h2) && is_indirect(src_mode)) begin
        ok = 1'b1;
      end
    end
    loopable = ok;
  endfunction

  function automatic lmt_cost_t add_cost(input lmt_cost_t a, input lmt_cost_t b);
    lmt_cost_t s;
    s.clocks = a.clocks + b.clocks;
    s.reads  = a.reads + b.reads;
    s.writes = a.writes + b.writes;
    add_cost = s;
  endfunction

  // Effective address cost; no entry carries a write
  function automatic lmt_cost_t ea_cost(input lmt_ea_mode_t mode,
                                        input logic lng, input logic fetch);
    logic [15:0] c;
    c = `LMT_COST_ZERO;
    unique case (mode)
      ea_dn, ea_an: c = `LMT_COST_ZERO;
      ea_ind: begin
        if (!fetch) c = `LMT_EA_IND_N;
        else if (lng) c = `LMT_EA_IND_F_L;
        else c = `LMT_EA_IND_F_BW;
      end
      ea_post: begin
        if (!fetch) c = `LMT_EA_POST_N;
        else if (lng) c = `LMT_EA_POST_F_L;
        else c = `LMT_EA_POST_F_BW;
      end
      ea_pre: begin
        if (!fetch) c = `LMT_EA_PRE_N;
        else if (lng) c = `LMT_EA_PRE_F_L;
        else c = `LMT_EA_PRE_F_BW;
      end
      ea_disp: begin
        if (!fetch) c = lng ? `LMT_EA_DISP_N_L : `LMT_EA_DISP_N_BW;
        else if (lng) c = `LMT_EA_DISP_F_L;
        else c = `LMT_EA_DISP_F_BW;
      end
      ea_idx: begin
        if (!fetch) c = `LMT_EA_IDX_N;
        else if (lng) c = `LMT_EA_IDX_F_L;
        else c = `LMT_EA_IDX_F_BW;
      end
      ea_absw: begin
        if (!fetch) c = `LMT_EA_ABSW_N;
        else if (lng) c = `LMT_EA_ABSW_F_L;
        else c = `LMT_EA_ABSW_F_BW;
      end
      ea_absl: begin
        if (!fetch) c = `LMT_EA_ABSL_N;
        else if (lng) c = `LMT_EA_ABSL_F_L;
        else c = `LMT_EA_ABSL_F_BW;
      end
      ea_pcd: c = lng ? `LMT_EA_PCD_F_L : `LMT_EA_PCD_F_BW;
      ea_pcx: c = lng ? `LMT_EA_PCX_F_L : `LMT_EA_PCX_F_BW;
      ea_imm: c = lng ? `LMT_EA_IMM_F_L : `LMT_EA_IMM_F_BW;
      default: c = `LMT_COST_ZERO;
    endcase
    c[3:0] = 4'h0;
    ea_cost = lmt_cost_t'(c);
  endfunction

  // Move cost: fetch plus source read plus destination write and extensions
  function automatic lmt_cost_t move_cost(input lmt_ea_mode_t src,
                                          input lmt_ea_mode_t dst,
                                          input logic lng);
    lmt_cost_t total;
    lmt_cost_t src_c;
    lmt_cost_t dst_c;
    total = lmt_cost_t'(`LMT_MOVE_BASE);
    if ((src == ea_pre) && !lng) begin
      src_c = lmt_cost_t'(`LMT_MOVE_PRE_SRC_BW);
    end else begin
      src_c = ea_cost(src, lng, 1'b1);
    end
    dst_c = lmt_cost_t'(`LMT_COST_ZERO);
    unique case (dst)
      ea_disp: dst_c = lmt_cost_t'(`LMT_MOVE_DST_DISP);
      ea_idx:  dst_c = lmt_cost_t'(`LMT_MOVE_DST_IDX);
      ea_absw: dst_c = lmt_cost_t'(`LMT_MOVE_DST_ABSW);
      ea_absl: dst_c = lmt_cost_t'(`LMT_MOVE_DST_ABSL);
      default: dst_c = lmt_cost_t'(`LMT_COST_ZERO);
    endcase
    total = add_cost(total, src_c);
    // Memory destinations add the write and any extension words
    if ((dst != ea_dn) && (dst != ea_an)) begin
      total = add_cost(total, lng ? lmt_cost_t'(`LMT_MOVE_WR_L)
                                  : lmt_cost_t'(`LMT_MOVE_WR_BW));
      total = add_cost(total, dst_c);
    end
    move_cost = total;
  endfunction

  // Loop entry, exit and exception acceptance
  always_comb begin
    next_arm_state      = arm_state;
    next_resume_pending = resume_pending;
    next_loop_active    = loop_active;
    next_skip_refetch   = 1'b0;
    next_loop_exit      = 1'b0;
    enter_loop          = 1'b0;
    exit_cond           = 1'b0;
    // Interrupts wait for the branch instruction while looping
    if (loop_active) begin
      next_irq_take = irq_pending && decrement_and_branch.valid;
    end else begin
      next_irq_take = irq_pending && instr_boundary;
    end
    next_trace_take = trace_en && (instr_boundary || decrement_and_branch.valid);
    // An exception accepted this cycle forbids any entry
    entry_block     = trace_en || next_irq_take;
    unique case (arm_state)
      arm_idle: begin
        if (decrement_and_branch.valid && decrement_and_branch.taken && (decrement_and_branch.disp == `LMT_LOOP_DISP) &&
            !trace_en && !loop_active) begin
          next_arm_state = arm_wait;
        end
      end
      arm_wait: begin
        if (trace_en || bus_error || irq_pending) begin
          next_arm_state = arm_idle;
        end else if (opword_valid) begin
          next_arm_state = arm_idle;
          enter_loop     = loopable(opword);
        end
      end
    endcase
    // Each exit cause counts only while looping
    exit_branch = loop_active && decrement_and_branch.valid && !decrement_and_branch.taken;
    exit_irq    = loop_active && decrement_and_branch.valid && irq_pending;
    exit_trace  = loop_active && trace_en;
    exit_bus    = loop_active && bus_error;
    exit_cond   = exit_branch || exit_irq || exit_trace || exit_bus;
    // Remember a loop cut by a bus error for the exception return
    if (exit_bus) begin
      next_resume_pending = 1'b1;
    end else if (rte_resume || (irq_pending && instr_boundary && !loop_active)) begin
      next_resume_pending = 1'b0;
    end
    // Exit wins over both kinds of entry
    if (exit_cond) begin
      next_loop_active = 1'b0;
      next_loop_exit   = 1'b1;
    end else if (rte_resume && resume_pending && !entry_block) begin
      next_loop_active  = 1'b1;
      next_skip_refetch = 1'b1;
    end else if (enter_loop && !entry_block) begin
      next_loop_active = 1'b1;
    end
  end

  // Outputs come straight from registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arm_state      <= arm_idle;
      resume_pending <= 1'b0;
      loop_active    <= 1'b0;
      irq_take       <= 1'b0;
      trace_take     <= 1'b0;
      loop_exit      <= 1'b0;
      skip_refetch   <= 1'b0;
    end else begin
      arm_state      <= next_arm_state;
      resume_pending <= next_resume_pending;
      loop_active    <= next_loop_active;
      irq_take       <= next_irq_take;
      trace_take     <= next_trace_take;
      loop_exit      <= next_loop_exit;
      skip_refetch   <= next_skip_refetch;
    end
  end

  // Cost tracking with wait-state stretch
  always_comb begin
    next_cost       = cost;
    next_cost_valid = 1'b0;
    // Move requests win over address requests
    if (move_req.valid) begin
      next_cost       = move_cost(move_req.src, move_req.dst, move_req.size_long);
      next_cost_valid = 1'b1;
    end else if (ea_req.valid) begin
      next_cost       = ea_cost(ea_req.mode, ea_req.size_long, ea_req.fetch);
      next_cost_valid = 1'b1;
    end else if (wait_state) begin
      next_cost.clocks = cost.clocks + `LMT_WAIT_CLK;
      next_cost_valid  = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cost       <= lmt_cost_t'(`LMT_COST_ZERO);
      cost_valid <= 1'b0;
    end else begin
      cost       <= next_cost;
      cost_valid <= next_cost_valid;
    end
  end

endmodule

/* File: tb/lmt_ctrl_monitor.sv */
// Purpose: Port-level checks on loop control and cost tracking
// Assumes: Outputs registered one edge after their cause
// Notes:   Single clock domain
module lmt_ctrl_monitor
  import lmt_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          rst,
  input wire logic          opword_valid,
  input wire lmt_decrement_and_branch_t     decrement_and_branch,
  input wire logic          trace_en,
  input wire logic          bus_error,
  input wire logic          rte_resume,
  input wire lmt_ea_req_t   ea_req,
  input wire lmt_move_req_t move_req,
  input wire logic          wait_state,
  input wire logic          loop_active,
  input wire logic          irq_take,
  input wire logic          loop_exit,
  input wire logic          skip_refetch,
  input wire logic          cost_valid,
  input wire lmt_cost_t     cost
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_entry_cause: assert property (
    $rose(loop_active) |-> $past(opword_valid) || $past(rte_resume)) else $error("bad entry");
  a_exit_flag: assert property (
    $fell(loop_active) |-> loop_exit) else $error("exit without pulse");
  a_trace_blocks: assert property (
    $rose(loop_active) && $past(opword_valid) |-> !$past(trace_en)) else $error("loop under trace");
  a_irq_at_branch: assert property (
    irq_take && $past(loop_active) |-> $past(decrement_and_branch.valid)) else $error("irq after looped op");
  a_irq_ends_loop: assert property (
    irq_take |-> !loop_active) else $error("loop kept on irq");
  a_bus_err_exit: assert property (
    loop_active && bus_error |=> !loop_active && loop_exit) else $error("loop kept on bus error");
  a_skip_refetch: assert property (
    skip_refetch |-> loop_active && $past(rte_resume)) else $error("bad resume");
  a_ea_no_write: assert property (
    cost_valid && $past(ea_req.valid) && !$past(move_req.valid) |-> cost.writes == 4'h0)
    else $error("write in address cost");
  a_cost_hold: assert property (
    !cost_valid |-> $stable(cost)) else $error("cost moved");
  a_wait_adds: assert property (
    $past(wait_state) && !$past(ea_req.valid) && !$past(move_req.valid)
    |-> cost.clocks == $past(cost.clocks) + 8'h01) else $error("wait not added");
endmodule

/* File: tb/lmt_mem_model.sv */
// Purpose: Memory side that stretches bus cycles with wait states
// Assumes: slow_req raised for one cycle per wait state
// Notes:   Output launched on the falling edge
module lmt_mem_model (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic slow_req,
  output logic      wait_state
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slow memory adds one wait state per request
  always @(negedge core_clk or posedge rst) begin
    if (rst) wait_state <= 1'b0;
    else wait_state <= slow_req;
  end
endmodule

/* File: tb/tb_lmt_ctrl.sv */
// Purpose: Directed scenarios for loop control and cost tracking
// Assumes: Inputs driven at the falling edge
// Notes:   Results read one falling edge after the taking edge
module tb_lmt_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import lmt_pkg::*;
  logic core_clk, rst, opword_valid, instr_boundary, irq_pending, trace_en;
  logic bus_error, rte_resume, slow_req, loop_active, irq_take, trace_take;
  logic loop_exit, skip_refetch, cost_valid, wait_state;
  logic [15:0] opword;
  lmt_decrement_and_branch_t decrement_and_branch;
  lmt_ea_req_t ea_req;
  lmt_move_req_t move_req;
  lmt_cost_t cost;
  int bad_count, tests_run, cycles;
  lmt_ea_mode_t md[16] = '{ea_post, ea_post, ea_post, ea_pre, ea_pre, ea_disp, ea_disp,
                           ea_idx, ea_idx, ea_absl, ea_absl, ea_absl,
                           ea_ind, ea_ind, ea_absw, ea_imm};
  logic [15:0] ex[16] = '{16'h0410, 16'h0820, 16'h0400, 16'h0810, 16'h0A20, 16'h0820,
                          16'h0C30, 16'h0A20, 16'h0E30, 16'h0C30, 16'h1040, 16'h0820,
                          16'h0410, 16'h0200, 16'h0C30, 16'h0820};
  logic [15:0] lg = 16'hE552;
  logic [15:0] fe = 16'hD7FB;
  lmt_ctrl i_dut (.core_clk(core_clk), .rst(rst), .opword_valid(opword_valid),
    .opword(opword), .decrement_and_branch(decrement_and_branch), .instr_boundary(instr_boundary),
    .irq_pending(irq_pending), .trace_en(trace_en), .bus_error(bus_error),
    .rte_resume(rte_resume), .ea_req(ea_req), .move_req(move_req),
    .wait_state(wait_state), .loop_active(loop_active), .irq_take(irq_take),
    .trace_take(trace_take), .loop_exit(loop_exit), .skip_refetch(skip_refetch),
    .cost_valid(cost_valid), .cost(cost));
  lmt_mem_model i_mem (.core_clk(core_clk), .rst(rst), .slow_req(slow_req),
    .wait_state(wait_state));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic br(input logic t, input logic [15:0] d);
    @(negedge core_clk) decrement_and_branch <= {1'b1, t, d};
    @(negedge core_clk) decrement_and_branch <= '0;
  endtask
  task automatic fetch(input logic [15:0] w);
    @(negedge core_clk) begin opword_valid <= 1'b1; opword <= w; end
    @(negedge core_clk) opword_valid <= 1'b0;
  endtask
  task automatic enter(input logic [15:0] w, input logic [15:0] exp);
    br(1'b1, 16'hFFFC);
    fetch(w);
    check(16'(loop_active), exp);
  endtask
  task automatic s_entry();
    logic [15:0] ok[3] = '{16'h32D8, 16'h32C0, 16'hD258};
    logic [15:0] no[2] = '{16'h4E71, 16'h3028};
    foreach (ok[i]) begin
      enter(ok[i], 16'h0001);
      br(1'b0, 16'hFFFC);
      check({14'h0, loop_exit, loop_active}, 16'h0002);
    end
    foreach (no[i]) enter(no[i], 16'h0000);
    br(1'b1, 16'hFFFA);
    fetch(16'h32D8);
    check(16'(loop_active), 16'h0000);
  endtask
  task automatic s_irq();
    enter(16'h32D8, 16'h0001);
    @(negedge core_clk) begin irq_pending <= 1'b1; instr_boundary <= 1'b1; end
    @(negedge core_clk) instr_boundary <= 1'b0;
    check({14'h0, irq_take, loop_active}, 16'h0001);
    br(1'b1, 16'hFFFC);
    check({13'h0, irq_take, loop_exit, loop_active}, 16'h0006);
    irq_pending <= 1'b0;
    enter(16'h32D8, 16'h0001);
    br(1'b0, 16'hFFFC);
    @(negedge core_clk) begin irq_pending <= 1'b1; instr_boundary <= 1'b1; end
    @(negedge core_clk) begin irq_pending <= 1'b0; instr_boundary <= 1'b0; end
    check({14'h0, irq_take, loop_active}, 16'h0002);
  endtask
  task automatic s_trace();
    trace_en <= 1'b1;
    enter(16'h32D8, 16'h0000);
    br(1'b1, 16'hFFFC);
    check(16'(trace_take), 16'h0001);
    trace_en <= 1'b0;
  endtask
  task automatic s_buserr();
    enter(16'h32D8, 16'h0001);
    @(negedge core_clk) bus_error <= 1'b1;
    @(negedge core_clk) bus_error <= 1'b0;
    check({14'h0, loop_exit, loop_active}, 16'h0002);
    @(negedge core_clk) rte_resume <= 1'b1;
    @(negedge core_clk) rte_resume <= 1'b0;
    check({14'h0, skip_refetch, loop_active}, 16'h0003);
    @(negedge core_clk) rst <= 1'b1;
    @(negedge core_clk) rst <= 1'b0;
    check(16'(loop_active), 16'h0000);
  endtask
  task automatic s_cost();
    foreach (md[i]) begin
      @(negedge core_clk) ea_req <= {1'b1, md[i], lg[i], fe[i]};
      @(negedge core_clk) ea_req <= '0;
      check(cost, ex[i]);
      check(16'(cost_valid), 16'h0001);
    end
    @(negedge core_clk) move_req <= {1'b1, ea_dn, ea_dn, 1'b0};
    @(negedge core_clk) move_req <= {1'b1, ea_dn, ea_ind, 1'b0};
    check(cost, 16'h0410);
    @(negedge core_clk) move_req <= '0;
    check(cost, 16'h0811);
    slow_req <= 1'b1;
    @(negedge core_clk) slow_req <= 1'b0;
    @(negedge core_clk);
    check(cost, 16'h0911);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    rst = 1'b1; opword_valid = 1'b0; opword = '0; decrement_and_branch = '0; instr_boundary = 1'b0;
    irq_pending = 1'b0; trace_en = 1'b0; bus_error = 1'b0; rte_resume = 1'b0;
    ea_req = '0; move_req = '0; slow_req = 1'b0;
    repeat (4) @(negedge core_clk);
    rst <= 1'b0;
    s_entry();
    s_irq();
    s_trace();
    s_buserr();
    s_cost();
    report_and_stop();
  end
endmodule
bind lmt_ctrl lmt_ctrl_monitor i_mon (.core_clk(core_clk), .rst(rst),
  .opword_valid(opword_valid), .decrement_and_branch(decrement_and_branch), .trace_en(trace_en), .bus_error(bus_error),
  .rte_resume(rte_resume), .ea_req(ea_req), .move_req(move_req), .wait_state(wait_state),
  .loop_active(loop_active), .irq_take(irq_take), .loop_exit(loop_exit),
  .skip_refetch(skip_refetch), .cost_valid(cost_valid), .cost(cost));
